// ---- hdl/power_monitor_defs.svh ----
// constants for the power monitor setup block: command codes, register
// indices, field positions, reset values and timing counts
// assumes a single 25 MHz clock
`ifndef POWER_MONITOR_DEFS_SVH
`define POWER_MONITOR_DEFS_SVH

// ****************************************************************
// target address
// ****************************************************************
`define ADDR_FIXED_BITS 3'h4
`define STRAP_GND 2'h0
`define STRAP_SUPPLY 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3

// ****************************************************************
// serial command codes and local register indices
// ****************************************************************
`define CMD_ADC_SETUP 8'h10
`define CMD_CURRENT_SCALE 8'h11
`define IDX_ADC_SETUP 2'h0
`define IDX_CURRENT_SCALE 2'h1
`define IDX_STATUS 2'h2

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define SETUP_WRITE_MASK 16'h0FFF
`define ADC_SETUP_RESET 16'h0127
`define CURRENT_SCALE_RESET 16'h0000
`define STAT_READY_BIT 7

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 40
`define TICK_NS 1000
`define US_TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_140_US 140
`define CONV_204_US 204
`define CONV_332_US 332
`define CONV_588_US 588
`define CONV_1100_US 1100

`endif

// ---- hdl/power_monitor_pkg.sv ----
// types shared by the power monitor setup block
// assumes nothing of its surroundings
package power_monitor_pkg;

	typedef struct packed {
		logic [3:0] reserved;
		logic [2:0] sample_avg_count;
		logic [2:0] bus_conv_time;
		logic [2:0] shunt_conv_time;
		logic [2:0] mode;
	} adc_setup_s;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'h1,
		SQ_SHUNT = 3'h2,
		SQ_BUS = 3'h4
	} seq_state_e;

	typedef enum logic [5:0] {
		IC_IDLE = 6'h01,
		IC_RECV = 6'h02,
		IC_ACK = 6'h04,
		IC_SEND = 6'h08,
		IC_HACK = 6'h10,
		IC_WAIT = 6'h20
	} i2c_state_e;

	typedef enum logic [2:0] {
		RX_ADDR = 3'h1,
		RX_CMD = 3'h2,
		RX_DATA = 3'h4
	} rx_phase_e;

endpackage

// ---- hdl/addr_strap_sense.sv ----
// senses what each address pin is tied to by watching it against the
// serial lines; the code settles after the first start and address bits
// assumes pins and serial lines synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "power_monitor_defs.svh"

module addr_strap_sense (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_pin_high,
	input wire logic addr_pin_low,
	output logic [3:0] strap_code
);

	logic [1:0] pins;
	assign pins = {addr_pin_high, addr_pin_low};

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			logic seen_hi_reg;
			logic seen_lo_reg;
			logic diff_sda_reg;
			logic diff_scl_reg;
			logic [1:0] code_reg;
			// flags are sticky: a strapped pin never changes while powered
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					seen_hi_reg <= 1'b0;
					seen_lo_reg <= 1'b0;
					diff_sda_reg <= 1'b0;
					diff_scl_reg <= 1'b0;
				end
				else
				begin
					seen_hi_reg <= seen_hi_reg | pins[g];
					seen_lo_reg <= seen_lo_reg | ~pins[g];
					diff_sda_reg <= diff_sda_reg | (pins[g] ^ sda_in);
					diff_scl_reg <= diff_scl_reg | (pins[g] ^ scl_in);
				end
			end
			always_ff @(posedge clk)
			begin
				if (srst)
					code_reg <= `STRAP_GND;
				else if (seen_hi_reg && seen_lo_reg && !diff_scl_reg)
					code_reg <= `STRAP_SCL;
				else if (seen_hi_reg && seen_lo_reg && !diff_sda_reg)
					code_reg <= `STRAP_SDA;
				else if (seen_hi_reg && !seen_lo_reg)
					code_reg <= `STRAP_SUPPLY;
				else
					code_reg <= `STRAP_GND;
			end
			assign strap_code[2*g+1:2*g] = code_reg;
		end
	endgenerate

endmodule // addr_strap_sense
`default_nettype wire

// ---- hdl/power_monitor_adc_setup.sv ----
// serial target, setup registers and conversion sequencer of the monitor
// assumes serial lines and pins synchronous to clk, open-drain sda
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "power_monitor_defs.svh"

module power_monitor_adc_setup #(
	parameter int unsigned TICK_CYCLES = `US_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_pin_high,
	input wire logic addr_pin_low,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic shunt_conv_active,
	output logic bus_conv_active,
	output logic result_store
);

	// ****************************************************************
	// registers and target address
	// ****************************************************************
	power_monitor_pkg::adc_setup_s adc_setup_reg;
	logic [15:0] current_scale_reg;
	logic ready_reg;
	logic [3:0] strap_code;
	logic [6:0] own_addr;
	logic i2c_wr;
	logic [7:0] ptr_reg;
	logic [15:0] word_reg;
	logic setup_wr;

	addr_strap_sense u_strap (
		.clk(clk),
		.srst(srst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.addr_pin_high(addr_pin_high),
		.addr_pin_low(addr_pin_low),
		.strap_code(strap_code)
	);

	assign own_addr = {`ADDR_FIXED_BITS, strap_code};

	assign setup_wr = (i2c_wr && ptr_reg == `CMD_ADC_SETUP) ||
		(reg_wr && reg_addr == `IDX_ADC_SETUP);

	// serial writes win over local writes in the same cycle
	// four fields writable
	always_ff @(posedge clk)
	begin
		if (srst)
			adc_setup_reg <= `ADC_SETUP_RESET;
		else if (i2c_wr && ptr_reg == `CMD_ADC_SETUP)
			adc_setup_reg <= word_reg & `SETUP_WRITE_MASK;
		else if (reg_wr && reg_addr == `IDX_ADC_SETUP)
			adc_setup_reg <= reg_wdata & `SETUP_WRITE_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			current_scale_reg <= `CURRENT_SCALE_RESET;
		else if (i2c_wr && ptr_reg == `CMD_CURRENT_SCALE)
			current_scale_reg <= word_reg;
		else if (reg_wr && reg_addr == `IDX_CURRENT_SCALE)
			current_scale_reg <= reg_wdata;
	end

	// result-ready flag: a new result beats a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			ready_reg <= 1'b0;
		else if (result_store)
			ready_reg <= 1'b1;
		else if (reg_wr && reg_addr == `IDX_STATUS &&
			reg_wdata[`STAT_READY_BIT])
			ready_reg <= 1'b0;
	end

	function automatic logic [15:0] reg_value(input logic [1:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		unique case (idx)
			`IDX_ADC_SETUP: v = adc_setup_reg;
			`IDX_CURRENT_SCALE: v = current_scale_reg;
			`IDX_STATUS: v = {7'h00, bus_conv_active | shunt_conv_active,
				ready_reg, own_addr};
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= reg_value(reg_addr);
		else
			reg_rdata <= 16'h0000;
	end

	// ****************************************************************
	// conversion sequencer
	// ****************************************************************
	power_monitor_pkg::seq_state_e seq_reg;
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
	logic tick;
	logic [10:0] time_cnt_reg;
	logic [10:0] samp_cnt_reg;
	logic trig_pend_reg;
	logic [2:0] mode;
	logic run_req;
	logic powered;
	logic [10:0] shunt_len;
	logic [10:0] bus_len;
	logic last_sample;

	function automatic logic [10:0] conv_len(input logic [2:0] code);
		logic [10:0] n;
		n = 11'(`CONV_1100_US);
		unique case (code)
			3'h0: n = 11'(`CONV_140_US);
			3'h1: n = 11'(`CONV_204_US);
			3'h2: n = 11'(`CONV_332_US);
			3'h3: n = 11'(`CONV_588_US);
			default: n = 11'(`CONV_1100_US);
		endcase
		return n;
	endfunction

	function automatic logic [10:0] avg_len(input logic [2:0] code);
		logic [10:0] n;
		n = 11'h001;
		unique case (code)
			3'h0: n = 11'h001;
			3'h1: n = 11'h004;
			3'h2: n = 11'h010;
			3'h3: n = 11'h040;
			3'h4: n = 11'h080;
			3'h5: n = 11'h100;
			3'h6: n = 11'h200;
			3'h7: n = 11'h400;
		endcase
		return n;
	endfunction

	assign mode = adc_setup_reg.mode;
	assign shunt_len = conv_len(adc_setup_reg.shunt_conv_time);
	assign bus_len = conv_len(adc_setup_reg.bus_conv_time);
	assign last_sample = (samp_cnt_reg + 11'h001) ==
		avg_len(adc_setup_reg.sample_avg_count);
	// codes 0 and 4 power down
	assign powered = mode[1:0] != 2'h0;
	assign run_req = powered && (mode[2] || trig_pend_reg);

	assign tick = tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYCLES - 1);

	always_ff @(posedge clk)
	begin
		if (srst || tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
	end

	// a setup write arms one triggered round
	always_ff @(posedge clk)
	begin
		if (srst)
			trig_pend_reg <= 1'b0;
		else if (setup_wr)
			trig_pend_reg <= 1'b1;
		else if (seq_reg == power_monitor_pkg::SQ_IDLE)
			trig_pend_reg <= 1'b0;
	end

	// new settings abort a round in progress rather than mix two setups
	always_ff @(posedge clk)
	begin
		result_store <= 1'b0;
		if (srst || setup_wr || !powered)
		begin
			seq_reg <= power_monitor_pkg::SQ_IDLE;
			time_cnt_reg <= 11'h000;
			samp_cnt_reg <= 11'h000;
		end
		else
		begin
			unique case (seq_reg)
				power_monitor_pkg::SQ_IDLE:
				begin
					time_cnt_reg <= 11'h000;
					samp_cnt_reg <= 11'h000;
					if (run_req)
						seq_reg <= mode[0] ? power_monitor_pkg::SQ_SHUNT :
							power_monitor_pkg::SQ_BUS;
				end
				power_monitor_pkg::SQ_SHUNT:
				begin
					if (tick)
						time_cnt_reg <= time_cnt_reg + 11'h001;
					if (tick && time_cnt_reg == shunt_len - 11'h001)
					begin
						time_cnt_reg <= 11'h000;
						if (mode[1])
							seq_reg <= power_monitor_pkg::SQ_BUS;
						else if (last_sample)
						begin
							result_store <= 1'b1;
							samp_cnt_reg <= 11'h000;
							if (!mode[2])
								seq_reg <= power_monitor_pkg::SQ_IDLE;
						end
						else
							samp_cnt_reg <= samp_cnt_reg + 11'h001;
					end
				end
				power_monitor_pkg::SQ_BUS:
				begin
					if (tick)
						time_cnt_reg <= time_cnt_reg + 11'h001;
					if (tick && time_cnt_reg == bus_len - 11'h001)
					begin
						time_cnt_reg <= 11'h000;
						if (last_sample)
						begin
							result_store <= 1'b1;
							samp_cnt_reg <= 11'h000;
							if (!mode[2])
								seq_reg <= power_monitor_pkg::SQ_IDLE;
							else if (mode[0])
								seq_reg <= power_monitor_pkg::SQ_SHUNT;
						end
						else
						begin
							samp_cnt_reg <= samp_cnt_reg + 11'h001;
							if (mode[0])
								seq_reg <= power_monitor_pkg::SQ_SHUNT;
						end
					end
				end
				default: seq_reg <= power_monitor_pkg::SQ_IDLE;
			endcase
		end
	end

	assign shunt_conv_active = seq_reg[1];
	assign bus_conv_active = seq_reg[2];

	// ****************************************************************
	// serial target
	// ****************************************************************
	power_monitor_pkg::i2c_state_e ic_reg;
	power_monitor_pkg::rx_phase_e phase_reg;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic ack_reg;
	logic hi_byte_reg;
	logic [15:0] rd_word;

	assign scl_rise = scl_in && !scl_d;
	assign scl_fall = !scl_in && scl_d;
	assign start_cond = scl_in && scl_d && sda_d && !sda_in;
	assign stop_cond = scl_in && scl_d && !sda_d && sda_in;
	assign rd_word = ptr_reg == `CMD_ADC_SETUP ? adc_setup_reg :
		ptr_reg == `CMD_CURRENT_SCALE ? current_scale_reg : 16'h0000;

	always_ff @(posedge clk)
	begin
		scl_d <= srst ? 1'b1 : scl_in;
		sda_d <= srst ? 1'b1 : sda_in;
		sda_out <= 1'b0;
	end

	// words go low byte first; the register updates on the high byte
	always_ff @(posedge clk)
	begin
		i2c_wr <= 1'b0;
		if (srst || stop_cond)
		begin
			ic_reg <= power_monitor_pkg::IC_IDLE;
			phase_reg <= power_monitor_pkg::RX_ADDR;
			sda_oe <= 1'b0;
			bit_reg <= 4'h0;
			ack_reg <= 1'b0;
			hi_byte_reg <= 1'b0;
			if (srst)
			begin
				ptr_reg <= 8'h00;
				shift_reg <= 8'h00;
				word_reg <= 16'h0000;
			end
		end
		else if (start_cond)
		begin
			ic_reg <= power_monitor_pkg::IC_RECV;
			phase_reg <= power_monitor_pkg::RX_ADDR;
			sda_oe <= 1'b0;
			bit_reg <= 4'h0;
			hi_byte_reg <= 1'b0;
		end
		else
		begin
			unique case (ic_reg)
				power_monitor_pkg::IC_IDLE, power_monitor_pkg::IC_WAIT:
					sda_oe <= 1'b0;
				power_monitor_pkg::IC_RECV:
				begin
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], sda_in};
						bit_reg <= bit_reg + 4'h1;
					end
					else if (scl_fall && bit_reg == 4'h8)
					begin
						ic_reg <= power_monitor_pkg::IC_ACK;
						bit_reg <= 4'h0;
						if (phase_reg == power_monitor_pkg::RX_ADDR)
						begin
							ack_reg <= shift_reg[0];
							sda_oe <= shift_reg[7:1] == own_addr;
							if (shift_reg[7:1] != own_addr)
								ic_reg <= power_monitor_pkg::IC_WAIT;
						end
						else
						begin
							sda_oe <= 1'b1;
							ack_reg <= 1'b0;
							if (phase_reg == power_monitor_pkg::RX_CMD)
							begin
								ptr_reg <= shift_reg;
								hi_byte_reg <= 1'b0;
							end
							else if (!hi_byte_reg)
							begin
								word_reg[7:0] <= shift_reg;
								hi_byte_reg <= 1'b1;
							end
							else
							begin
								word_reg[15:8] <= shift_reg;
								hi_byte_reg <= 1'b0;
								i2c_wr <= 1'b1;
							end
						end
					end
				end
				power_monitor_pkg::IC_ACK:
				begin
					if (scl_fall)
					begin
						if (ack_reg)
						begin
							ic_reg <= power_monitor_pkg::IC_SEND;
							shift_reg <= {rd_word[6:0], 1'b0};
							sda_oe <= !rd_word[7];
							hi_byte_reg <= 1'b0;
						end
						else
						begin
							ic_reg <= power_monitor_pkg::IC_RECV;
							sda_oe <= 1'b0;
							phase_reg <= phase_reg == power_monitor_pkg::RX_ADDR ?
								power_monitor_pkg::RX_CMD :
								power_monitor_pkg::RX_DATA;
						end
					end
				end
				power_monitor_pkg::IC_SEND:
				begin
					if (scl_rise)
						bit_reg <= bit_reg + 4'h1;
					else if (scl_fall && bit_reg == 4'h8)
					begin
						ic_reg <= power_monitor_pkg::IC_HACK;
						sda_oe <= 1'b0;
						bit_reg <= 4'h0;
					end
					else if (scl_fall)
					begin
						sda_oe <= !shift_reg[7];
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				power_monitor_pkg::IC_HACK:
				begin
					if (scl_rise)
						ack_reg <= !sda_in;
					else if (scl_fall && ack_reg)
					begin
						// same word back, high byte second
						ic_reg <= power_monitor_pkg::IC_SEND;
						hi_byte_reg <= !hi_byte_reg;
						if (hi_byte_reg)
						begin
							shift_reg <= {rd_word[6:0], 1'b0};
							sda_oe <= !rd_word[7];
						end
						else
						begin
							shift_reg <= {rd_word[14:8], 1'b0};
							sda_oe <= !rd_word[15];
						end
					end
					else if (scl_fall)
						ic_reg <= power_monitor_pkg::IC_WAIT;
				end
				default: ic_reg <= power_monitor_pkg::IC_IDLE;
			endcase
		end
	end

endmodule // power_monitor_adc_setup
`default_nettype wire

// ---- bench/power_monitor_adc_setup_properties.sv ----
// concurrent checks for the power monitor setup block
// sees only the top module ports; one clock, srst synchronous
`timescale 1ns/10ps
`default_nettype none
module power_monitor_adc_setup_checker #(
	parameter int unsigned TICK_CYCLES = 25
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic addr_pin_high,
	input wire logic addr_pin_low,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic shunt_conv_active,
	input wire logic bus_conv_active,
	input wire logic result_store
);
	// ****************************************************************
	// helpers and checks
	// ****************************************************************
	logic [15:0] scale_shadow;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// serial scale writes are not tracked here, the bench never makes them
	always_ff @(posedge clk)
	begin
		if (srst)
			scale_shadow <= 16'h0000;
		else if (reg_wr && reg_addr == 2'h1)
			scale_shadow <= reg_wdata;
	end
	sequence s_rd(logic [1:0] idx);
		reg_rd && reg_addr == idx;
	endsequence
	AST_SCALE_BACK: assert property (
		s_rd(2'h1) |=> reg_rdata == scale_shadow)
		else $error("scale read differs from last write");
	AST_UNMAPPED: assert property (
		s_rd(2'h3) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_SETUP_RSV: assert property (
		s_rd(2'h0) |=> reg_rdata[15:12] == 4'h0)
		else $error("setup spare bits not zero");
	AST_OWN_ADDR: assert property (
		s_rd(2'h2) |=> reg_rdata[6:4] == 3'h4)
		else $error("own address upper bits wrong");
	AST_RDATA_QUIET: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	AST_ONE_CONV: assert property (!(shunt_conv_active && bus_conv_active))
		else $error("shunt and bus converting together");
	AST_STORE_PULSE: assert property (result_store |=> !result_store)
		else $error("store pulse longer than one cycle");
	AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	AST_ACK_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda drive changed while scl high");
endmodule // power_monitor_adc_setup_checker

bind power_monitor_adc_setup power_monitor_adc_setup_checker #(
	.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .srst(srst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.addr_pin_high(addr_pin_high), .addr_pin_low(addr_pin_low),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.shunt_conv_active(shunt_conv_active),
	.bus_conv_active(bus_conv_active), .result_store(result_store));
`default_nettype wire

// ---- bench/i2c_host_model.sv ----
// serial bus host that configures the monitor
// assumes an open-drain sda with pull-up, resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// ****************************************************************
	// bit and frame tasks
	// ****************************************************************
	localparam int QTR = 4;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wait_q();
		repeat (QTR) @(posedge clk);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		wait_q();
		scl <= 1'b1;
		wait_q();
		sda_low <= 1'b1;
		wait_q();
		scl <= 1'b0;
		wait_q();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		wait_q();
		scl <= 1'b1;
		wait_q();
		sda_low <= 1'b0;
		wait_q();
	endtask
	// sda only moves while scl is low
	task automatic put_bit(input logic b, output logic got);
		sda_low <= !b;
		wait_q();
		scl <= 1'b1;
		wait_q();
		@(negedge clk) got = sda_line;
		@(posedge clk) scl <= 1'b0;
		wait_q();
	endtask
	// msb first, ninth bit is acknowledge
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(d[i], g);
			q[i] = g;
		end
		put_bit(last, g);
		ack = !g;
	endtask
endmodule // i2c_host_model
`default_nettype wire

// ---- bench/power_monitor_adc_setup_tb.sv ----
// self-checking bench for the power monitor setup block
// local port and serial host both drive on the rising edge
`timescale 1ns/10ps
`default_nettype none
`include "power_monitor_defs.svh"
module power_monitor_adc_setup_tb;
	// ****************************************************************
	// wiring
	// ****************************************************************
	localparam int TICK = 1;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [3:0] strap = 4'h0;
	logic [15:0] reg_rdata;
	logic sda_out, sda_oe, shunt_conv_active, bus_conv_active, result_store;
	logic scl, host_low, sda_line, pin_hi, pin_lo;
	int err_count = 0;
	int check_count = 0;
	always #20 clk = ~clk;
	function automatic logic tie(input logic [1:0] s, input logic d,
		input logic c);
		return s == `STRAP_GND ? 1'b0 : s == `STRAP_SUPPLY ? 1'b1 :
			s == `STRAP_SDA ? d : c;
	endfunction
	assign sda_line = !(host_low || sda_oe);
	// pins tied to gnd, supply, sda or scl
	assign pin_hi = tie(strap[3:2], sda_line, scl);
	assign pin_lo = tie(strap[1:0], sda_line, scl);
	power_monitor_adc_setup #(.TICK_CYCLES(TICK)) u_dut (.clk(clk),
		.srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_pin_high(pin_hi), .addr_pin_low(pin_lo),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shunt_conv_active(shunt_conv_active),
		.bus_conv_active(bus_conv_active), .result_store(result_store));
	i2c_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl),
		.sda_low(host_low));
	// ****************************************************************
	// expectations and tasks
	// ****************************************************************
	function automatic int conv_us(input logic [2:0] c);
		return c == 3'h0 ? `CONV_140_US : c == 3'h1 ? `CONV_204_US :
			c == 3'h2 ? `CONV_332_US : c == 3'h3 ? `CONV_588_US : `CONV_1100_US;
	endfunction
	function automatic int avg_n(input logic [2:0] c);
		return c < 3'h4 ? 1 << (2 * c) : 1 << (c + 3);
	endfunction
	// step from max current over 2^15, then 0.00512 / (step * shunt)
	function automatic logic [15:0] scale_from(input real imax, input real rsh);
		real lsb;
		lsb = imax / 32768.0;
		return 16'($rtoi(0.00512 / (lsb * rsh)));
	endfunction
	// within two cycles: one tick of phase plus the store cycle
	function automatic logic [15:0] near(input int got, input int exp);
		return 16'(got >= exp - 2 && got <= exp + 2);
	endfunction
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk) reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [15:0] q);
		@(posedge clk) reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk) reg_rd <= 1'b0;
		@(negedge clk) q = reg_rdata;
	endtask
	task automatic do_reset();
		@(posedge clk) srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
	endtask
	task automatic watch(input int n, output int sr, br, st, sl, bl);
		logic ps, pb;
		{sr, br, st, sl, bl, ps, pb} = '0;
		repeat (n)
		begin
			@(negedge clk);
			sr += int'(shunt_conv_active && !ps);
			br += int'(bus_conv_active && !pb);
			// single-channel continuous modes never drop active
			sl += int'(shunt_conv_active && sr == 1 && st == 0);
			bl += int'(bus_conv_active && br == 1 && st == 0);
			st += int'(result_store === 1'b1);
			ps = shunt_conv_active;
			pb = bus_conv_active;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#(40 * 95000);
		err_count++;
		tally_and_finish();
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		logic [15:0] q, v;
		logic [7:0] lo, hi;
		logic ack, on;
		logic [2:0] ts, tb, av;
		int sr, br, st, sl, bl, rnd;
		void'($urandom(63));
		do_reset();
		rd(`IDX_ADC_SETUP, q);
		check("setup reset", `ADC_SETUP_RESET, q);
		rd(`IDX_CURRENT_SCALE, q);
		check("scale reset", `CURRENT_SCALE_RESET, q);
		wr(2'h3, 16'($urandom));
		rd(2'h3, q);
		check("unmapped", 16'h0000, q);
		repeat (6)
		begin
			v = 16'($urandom);
			wr(`IDX_ADC_SETUP, v);
			wr(`IDX_CURRENT_SCALE, ~v);
			rd(`IDX_ADC_SETUP, q);
			check("setup back", v & `SETUP_WRITE_MASK, q);
			rd(`IDX_CURRENT_SCALE, q);
			check("scale back", ~v, q);
		end
		wr(`IDX_CURRENT_SCALE, scale_from(10.0, 0.002));
		rd(`IDX_CURRENT_SCALE, q);
		check("scale calc", scale_from(10.0, 0.002), q);
		$display("test local registers done");
		// every mode; both-measuring modes are among them
		for (int m = 0; m < 8; m++)
		begin
			ts = 3'($urandom % (m == 3 ? 4 : 8));
			tb = 3'($urandom % (m == 3 ? 4 : 8));
			av = (m == 3) ? 3'h1 : 3'h0;
			on = (m[1:0] != 2'h0);
			rnd = (m[0] ? conv_us(ts) : 0) + (m[1] ? conv_us(tb) : 0);
			rnd = on ? rnd * TICK : 100;
			wr(`IDX_ADC_SETUP, {4'h0, av, tb, ts, 3'(m)});
			watch(rnd * (avg_n(av) + 2) + 100, sr, br, st, sl, bl);
			if (m[2] && on)
				check("runs on", 16'h1, 16'(st >= 2));
			else
			begin
				check("stores", 16'(on), 16'(st));
				check("shunt n", 16'(m[0] ? avg_n(av) : 0), 16'(sr));
				check("bus n", 16'(m[1] ? avg_n(av) : 0), 16'(br));
			end
			if (m[0] && on)
				check("shunt t", 16'h1, near(sl, conv_us(ts) * TICK));
			if (m[1] && on)
				check("bus t", 16'h1, near(bl, conv_us(tb) * TICK));
		end
		rd(`IDX_STATUS, q);
		check("ready set", 16'h1, 16'(q[`STAT_READY_BIT]));
		wr(`IDX_ADC_SETUP, 16'h0000);
		wr(`IDX_STATUS, 16'h0080);
		rd(`IDX_STATUS, q);
		check("ready clr busy", 16'h0, 16'(q[8:7]));
		$display("test modes done");
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk) strap <= 4'(i);
			do_reset();
			u_host.start();
			u_host.xfer(8'hA5, 1'b1, lo, ack);
			u_host.stop();
			rd(`IDX_STATUS, q);
			check("own addr", {9'h0, `ADDR_FIXED_BITS, 4'(i)}, {9'h0, q[6:0]});
			u_host.start();
			u_host.xfer({`ADDR_FIXED_BITS, 4'(i) ^ 4'h1, 1'b0}, 1'b1, lo, ack);
			u_host.stop();
			check("other addr", 16'h0, 16'(ack));
			v = 16'($urandom);
			u_host.start();
			u_host.xfer({`ADDR_FIXED_BITS, 4'(i), 1'b0}, 1'b1, lo, ack);
			check("addr ack", 16'h1, 16'(ack));
			u_host.xfer(`CMD_ADC_SETUP, 1'b1, lo, ack);
			u_host.xfer(v[7:0], 1'b1, lo, ack);
			u_host.xfer(v[15:8], 1'b1, lo, ack);
			u_host.start();
			u_host.xfer({`ADDR_FIXED_BITS, 4'(i), 1'b1}, 1'b1, lo, ack);
			u_host.xfer(8'hFF, 1'b0, lo, ack);
			u_host.xfer(8'hFF, 1'b1, hi, ack);
			u_host.stop();
			check("serial back", v & `SETUP_WRITE_MASK, {hi, lo});
			rd(`IDX_ADC_SETUP, q);
			check("serial write", v & `SETUP_WRITE_MASK, q);
		end
		$display("test addresses done");
		tally_and_finish();
	end
endmodule // power_monitor_adc_setup_tb
`default_nettype wire
